/* File: src/sesum_pkg.sv */
// Purpose: Constants for the status and event summary block
// Assumes: 16-bit condition registers, 8-bit summary byte
// Notes:   Register selects are local to this block's read port
package sesum_pkg;
  localparam int COND_W = 16;
  localparam int SUM_W  = 8;
  // Run-state condition bit positions
  localparam int OP_WAIT_TRIG  = 5;
  localparam int OP_TRAN_ARM   = 6;
  localparam int OP_CONST_V    = 8;
  localparam int OP_TRAN_DONE  = 9;
  localparam int OP_CONST_I    = 10;
  localparam int OP_SAMPLE     = 11;
  localparam int OP_LIST_DONE  = 12;
  localparam int OP_LIST_RUN   = 14;
  // Signal-quality condition bit positions
  localparam int QU_CUR_MODE   = 0;
  localparam int QU_VOLT_MODE  = 1;
  localparam int QU_THERMAL    = 3;
  localparam int QU_SLAVE      = 6;
  localparam int QU_VPROT      = 12;
  localparam int QU_IPROT      = 13;
  localparam int QU_SINK       = 14;
  // Summary byte bit positions
  localparam int SR_QUALITY    = 3;
  localparam int SR_MSG_AVAIL  = 4;
  localparam int SR_STD_EVENT  = 5;
  localparam int SR_REQUEST    = 6;
  localparam int SR_RUN_STATE  = 7;
  // Read selects
  localparam logic [2:0] SEL_OP_COND  = 3'h0;
  localparam logic [2:0] SEL_OP_EVENT = 3'h1;
  localparam logic [2:0] SEL_QU_COND  = 3'h2;
  localparam logic [2:0] SEL_QU_EVENT = 3'h3;
  localparam logic [2:0] SEL_SUMMARY  = 3'h4;
  localparam logic [15:0] ZERO16      = 16'h0000;
  localparam logic [15:0] OP_ENB_RST  = 16'h0000;
  localparam logic [15:0] QU_ENB_RST  = 16'h0000;
  localparam logic [7:0]  SR_ENB_RST  = 8'h00;
endpackage

/* File: src/sesum_event_reg.sv */
// Purpose: Rising-edge event register with clear on read and enable mask
// Assumes: Condition input is synchronous to core_clk
// Notes:   A new edge in the clearing cycle is kept
`timescale 1ns/100ps
module sesum_event_reg #(
  parameter int WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] edgeIn,
  input  wire logic             readClear,
  input  wire logic [WIDTH-1:0] enableMask,
  output logic      [WIDTH-1:0] eventBits,
  output logic                  summary
);
  logic [WIDTH-1:0] prevIn;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prevIn <= '0;
    end else if (clkEn) begin
      prevIn <= edgeIn;
    end
  end

  // Set wins over read clear
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      eventBits <= '0;
    end else if (clkEn) begin
      eventBits <= (readClear ? '0 : eventBits) | (edgeIn & ~prevIn);
    end
  end

  assign summary = |(eventBits & enableMask);
endmodule

/* File: src/sesum_status_summary.sv */
// Purpose: Condition, event and service-request summary for a power supply
// Assumes: All status inputs come from logic on core_clk except trigPin
// Notes:   Reads via regSel/regRead; enables written via enable ports
//
// How it works
// - Summary bit 3 reads zero when no error and no quality event exist.
// - Summary bit 4 is set while a query response waits for reading.
// - Condition and event registers are 16 bits; the summary byte is 8.
// - Each condition register has an enable mask gating its events to summary.
// - An event bit sets when its condition bit rises from zero to one; run-state bits 9 and 12 set when transientDone and listDone rise.
// - Reading an event register returns it and then clears every bit not set by a new edge in that cycle.
// - Enabled set quality event bit asserts summary bit 3.
// - Summary bit 3 also set while the error queue is not empty.
// - Summary bits other than 6 are masked, ORed, and placed in bit 6.
// - SRQ is asserted while summary bit 6 is one.
// - Run-state bits 0-4, 7, 13, 15 always read zero.
// - Bit 5 set while trigger enabled; held through low external trigger input.
// - Bit 6 reads one only while the transient function is enabled.
// - Bit 8 marks constant voltage, bit 10 constant current.
// - Bits 9 and 12 are events only, reading zero in the condition.
// - Bit 11 marks sample complete, bit 14 list running.
// - Quality bit 0 means current mode, bit 1 voltage mode.
// - Quality bit 3 is thermal error, bit 6 slave fault.
// - Quality bits 12/13 are protection errors; with external reference, either error sets both.
// - Quality bit 14 is set while the unit sinks energy.
// - Quality bits 2, 4, 5, 7-11, 15 always read zero.
`timescale 1ns/100ps
module sesum_status_summary
  import sesum_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              clkEn,
  input  wire logic              trigEnabled,
  input  wire logic              trigSourceExt,
  input  wire logic              trigPin,
  input  wire logic              transientArmed,
  input  wire logic              transientDone,
  input  wire logic              constVoltage,
  input  wire logic              constCurrent,
  input  wire logic              sampleDone,
  input  wire logic              listDone,
  input  wire logic              listRunning,
  input  wire logic              thermalError,
  input  wire logic              slaveFault,
  input  wire logic              voltProtError,
  input  wire logic              currProtError,
  input  wire logic              extRefEnabled,
  input  wire logic              sinking,
  input  wire logic              errQueueNotEmpty,
  input  wire logic              outputMsgReady,
  input  wire logic              stdEventSummary,
  input  wire logic              opEnableWrite,
  input  wire logic [COND_W-1:0] opEnableData,
  input  wire logic              quEnableWrite,
  input  wire logic [COND_W-1:0] quEnableData,
  input  wire logic              srEnableWrite,
  input  wire logic [SUM_W-1:0]  srEnableData,
  input  wire logic              regRead,
  input  wire logic [2:0]        regSel,
  output logic      [COND_W-1:0] regData,
  output logic      [SUM_W-1:0]  service_request_summary,
  output logic                   srqOut,
  output logic                   srqOe
);
  logic              trigSync1;
  logic              trigSync2;
  logic              waiting_trigger_flag;
  logic [COND_W-1:0] run_state_condition;
  logic [COND_W-1:0] run_state_edges;
  logic [COND_W-1:0] signal_quality_condition;
  logic [COND_W-1:0] run_state_enable;
  logic [COND_W-1:0] quality_enable_mask;
  logic [SUM_W-1:0]  srEnable;
  logic [COND_W-1:0] run_state_status;
  logic [COND_W-1:0] signal_quality_status;
  logic              opSummary;
  logic              quSummary;
  logic              opReadClear;
  logic              quReadClear;
  logic              anyProt;
  logic [SUM_W-1:0]  srBase;
  logic [COND_W-1:0] next_regData;

  // Trigger pin synchroniser
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      trigSync1 <= 1'b0;
      trigSync2 <= 1'b0;
    end else if (clkEn) begin
      trigSync1 <= trigPin;
      trigSync2 <= trigSync1;
    end
  end

  // Waiting for trigger, held while external trigger input is low
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      waiting_trigger_flag <= 1'b0;
    end else if (clkEn) begin
      if (trigEnabled) begin
        waiting_trigger_flag <= 1'b1;
      end else if (trigSourceExt && !trigSync2 && waiting_trigger_flag) begin
        waiting_trigger_flag <= 1'b1;
      end else begin
        waiting_trigger_flag <= 1'b0;
      end
    end
  end

  // Run-state condition as read; unused bits stay zero
  always_comb begin
    run_state_condition = ZERO16;
    run_state_condition[OP_WAIT_TRIG] = waiting_trigger_flag;
    run_state_condition[OP_TRAN_ARM]  = transientArmed;
    run_state_condition[OP_CONST_V]   = constVoltage;
    run_state_condition[OP_CONST_I]   = constCurrent;
    run_state_condition[OP_SAMPLE]    = sampleDone;
    run_state_condition[OP_LIST_RUN]  = listRunning;
  end

  // Edge source adds event-only bits
  always_comb begin
    run_state_edges = run_state_condition;
    run_state_edges[OP_TRAN_DONE] = transientDone;
    run_state_edges[OP_LIST_DONE] = listDone;
  end

  assign anyProt = voltProtError | currProtError;

  always_comb begin
    signal_quality_condition = ZERO16;
    signal_quality_condition[QU_CUR_MODE]  = constCurrent;
    signal_quality_condition[QU_VOLT_MODE] = constVoltage;
    signal_quality_condition[QU_THERMAL]   = thermalError;
    signal_quality_condition[QU_SLAVE]     = slaveFault;
    signal_quality_condition[QU_VPROT]     = voltProtError | (extRefEnabled & anyProt);
    signal_quality_condition[QU_IPROT]     = currProtError | (extRefEnabled & anyProt);
    signal_quality_condition[QU_SINK]      = sinking;
  end

  // Enable mask registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      run_state_enable    <= OP_ENB_RST;
      quality_enable_mask <= QU_ENB_RST;
      srEnable            <= SR_ENB_RST;
    end else if (clkEn) begin
      if (opEnableWrite) begin
        run_state_enable <= opEnableData;
      end
      if (quEnableWrite) begin
        quality_enable_mask <= quEnableData;
      end
      if (srEnableWrite) begin
        srEnable <= srEnableData;
      end
    end
  end

  assign opReadClear = regRead && (regSel == SEL_OP_EVENT);
  assign quReadClear = regRead && (regSel == SEL_QU_EVENT);

  sesum_event_reg #(
    .WIDTH (COND_W)
  ) uOpEvent (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .edgeIn     (run_state_edges),
    .readClear  (opReadClear),
    .enableMask (run_state_enable),
    .eventBits  (run_state_status),
    .summary    (opSummary)
  );

  sesum_event_reg #(
    .WIDTH (COND_W)
  ) uQuEvent (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .clkEn      (clkEn),
    .edgeIn     (signal_quality_condition),
    .readClear  (quReadClear),
    .enableMask (quality_enable_mask),
    .eventBits  (signal_quality_status),
    .summary    (quSummary)
  );

  // Summary byte, combinational
  always_comb begin
    srBase = '0;
    srBase[SR_QUALITY]   = quSummary | errQueueNotEmpty;
    srBase[SR_MSG_AVAIL] = outputMsgReady;
    srBase[SR_STD_EVENT] = stdEventSummary;
    srBase[SR_RUN_STATE] = opSummary;
    service_request_summary = srBase;
    service_request_summary[SR_REQUEST] = |(srBase & srEnable);
  end

  // SRQ open-drain: drive low while requesting
  assign srqOut = 1'b0;
  assign srqOe  = service_request_summary[SR_REQUEST];

  // Read data; event contents captured before the clear takes effect
  always_comb begin
    next_regData = regData;
    if (regRead) begin
      if (regSel == SEL_OP_COND) begin
        next_regData = run_state_condition;
      end else if (regSel == SEL_OP_EVENT) begin
        next_regData = run_state_status;
      end else if (regSel == SEL_QU_COND) begin
        next_regData = signal_quality_condition;
      end else if (regSel == SEL_QU_EVENT) begin
        next_regData = signal_quality_status;
      end else if (regSel == SEL_SUMMARY) begin
        next_regData = {8'h00, service_request_summary};
      end else begin
        next_regData = ZERO16;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      regData <= ZERO16;
    end else if (clkEn) begin
      regData <= next_regData;
    end
  end
endmodule

/* File: verif/sesum_status_summary_props.sv */
// Purpose: Port checks for the status summary block
// Assumes: One clock domain, reset active low
// Notes:   Bound to every instance of the block
`timescale 1ns/100ps
module sesum_status_summary_props
  import sesum_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic              clkEn,
  input wire logic              transientArmed,
  input wire logic              constVoltage,
  input wire logic              constCurrent,
  input wire logic              errQueueNotEmpty,
  input wire logic              outputMsgReady,
  input wire logic              regRead,
  input wire logic [2:0]        regSel,
  input wire logic [COND_W-1:0] regData,
  input wire logic [SUM_W-1:0]  service_request_summary,
  input wire logic              srqOe
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_srq_follows_req: assert property ((srqOe == service_request_summary[SR_REQUEST]) && (!srqOe ||
    (service_request_summary & 8'hBF) != 8'h00)) else $error("srq drive differs from request bit");
  a_msg_ready_bit: assert property (service_request_summary[SR_MSG_AVAIL] == outputMsgReady)
    else $error("message bit differs from ready input");
  a_queue_sets_bit: assert property (errQueueNotEmpty |-> service_request_summary[SR_QUALITY])
    else $error("queue entry without summary bit");
  a_op_unused_zero: assert property (regRead && clkEn && regSel == SEL_OP_COND |=>
    (regData & 16'hB29F) == ZERO16) else $error("unused run bit read as one");
  a_qu_unused_zero: assert property (regRead && clkEn && regSel == SEL_QU_COND |=>
    (regData & 16'h8FB4) == ZERO16) else $error("unused quality bit read as one");
  a_cv_bit_read: assert property (regRead && clkEn && regSel == SEL_OP_COND && constVoltage
    && $past(constVoltage) && $past(rst_n) |=> regData[OP_CONST_V]) else $error("voltage mode bit missing");
  a_cc_bit_read: assert property (regRead && clkEn && regSel == SEL_OP_COND && constCurrent
    && $past(constCurrent) && $past(rst_n) |=> regData[OP_CONST_I]) else $error("current mode bit missing");
  a_armed_bit_read: assert property (regRead && clkEn && regSel == SEL_OP_COND && $stable(transientArmed)
    && $past(rst_n) |=> regData[OP_TRAN_ARM] == $past(transientArmed)) else $error("armed bit wrong");
endmodule
bind sesum_status_summary sesum_status_summary_props chk_u (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn),
  .transientArmed(transientArmed), .constVoltage(constVoltage), .constCurrent(constCurrent),
  .errQueueNotEmpty(errQueueNotEmpty), .outputMsgReady(outputMsgReady), .regRead(regRead), .regSel(regSel),
  .regData(regData), .service_request_summary(service_request_summary), .srqOe(srqOe));

/* File: verif/sesum_gpib_host.sv */
// Purpose: Host side of the request line
// Assumes: Line is pulled up when no device pulls it
// Notes:   Serial poll reads are made by the bench
`timescale 1ns/100ps
module sesum_gpib_host (
  input  wire logic srqOut,
  input  wire logic srqOe,
  output logic      srqLine_n
);
  assign srqLine_n = srqOe ? srqOut : 1'b1;
endmodule

/* File: verif/sesum_status_summary_tb_top.sv */
// Purpose: Self-checking bench for the status summary block
// Assumes: Reads answer one cycle after the request edge
// Notes:   Random status traffic mixed with directed cases
`timescale 1ns/100ps
module sesum_status_summary_tb_top
  import sesum_pkg::*;
;
  logic        core_clk, rst_n, clkEn, opEnableWrite, quEnableWrite, srEnableWrite, regRead, srqOut, srqOe, srqLine_n;
  logic [18:0] sts;
  logic [15:0] enData, regData, d;
  logic [7:0]  srs;
  logic [2:0]  regSel;
  int          err_total, n_compared, seed, k;
  sesum_status_summary dut_u (.core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .trigEnabled(sts[0]),
    .trigSourceExt(sts[1]), .trigPin(sts[2]), .transientArmed(sts[3]), .transientDone(sts[4]),
    .constVoltage(sts[5]), .constCurrent(sts[6]), .sampleDone(sts[7]), .listDone(sts[8]), .listRunning(sts[9]),
    .thermalError(sts[10]), .slaveFault(sts[11]), .voltProtError(sts[12]), .currProtError(sts[13]),
    .extRefEnabled(sts[14]), .sinking(sts[15]), .errQueueNotEmpty(sts[16]), .outputMsgReady(sts[17]),
    .stdEventSummary(sts[18]), .opEnableWrite(opEnableWrite), .opEnableData(enData),
    .quEnableWrite(quEnableWrite), .quEnableData(enData), .srEnableWrite(srEnableWrite),
    .srEnableData(enData[7:0]), .regRead(regRead), .regSel(regSel), .regData(regData),
    .service_request_summary(srs), .srqOut(srqOut), .srqOe(srqOe));
  sesum_gpib_host host_u (.srqOut(srqOut), .srqOe(srqOe), .srqLine_n(srqLine_n));
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  function automatic logic [15:0] opExp(logic [18:0] s);
    opExp = {1'b0, s[9], 2'b00, s[7], s[6], 1'b0, s[5], 1'b0, s[3], s[0], 5'h00};
  endfunction
  function automatic logic [15:0] quExp(logic [7:0] q);
    logic e;
    e = q[4] & (q[2] | q[3]);
    quExp = {1'b0, q[5], q[3] | e, q[2] | e, 5'h00, q[1], 2'b00, q[0], 1'b0, q[6], q[7]};
  endfunction
  task automatic chk(logic [15:0] got, logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic drv(logic [18:0] v, int n);
    @(posedge core_clk);
    sts <= v;
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic rd(logic [2:0] sel);
    @(posedge core_clk);
    regRead <= 1'b1;
    regSel <= sel;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(posedge core_clk);
    #1 d = regData;
  endtask
  task automatic wr(logic [2:0] w, logic [15:0] v);
    @(posedge core_clk);
    {srEnableWrite, quEnableWrite, opEnableWrite} <= w;
    enData <= v;
    @(posedge core_clk);
    {srEnableWrite, quEnableWrite, opEnableWrite} <= 3'h0;
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (10000) @(posedge core_clk);
    err_total++;
    complete_run();
  end
  initial begin
    seed = 98;
    {rst_n, opEnableWrite, quEnableWrite, srEnableWrite, regRead, regSel, enData, sts} = '0;
    clkEn = 1'b1;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    chk({8'h00, srs}, 16'h0000);
    for (k = 0; k < 150; k++) begin
      drv(19'($random(seed)) & 19'h7FFFD, 3);
      rd(SEL_OP_COND);
      chk(d, opExp(sts));
    end
    for (k = 0; k < 256; k++) begin
      drv({3'h0, k[5:0], 3'h0, k[7:6], 5'h00}, 3);
      rd(SEL_QU_COND);
      chk(d, quExp(k[7:0]));
    end
    drv(19'h0, 3);
    rd(3'h7);
    chk(d, 16'h0000);
    rd(SEL_OP_EVENT);
    rd(SEL_QU_EVENT);
    chk({8'h00, srs}, 16'h0000);
    wr(3'h2, 16'h0008);
    wr(3'h4, 16'h0008);
    drv(19'h00400, 3);
    chk({8'h00, srs}, 16'h0048);
    chk({15'h0, srqLine_n}, 16'h0000);
    rd(SEL_QU_EVENT);
    chk(d, 16'h0008);
    rd(SEL_QU_EVENT);
    chk(d, 16'h0000);
    drv(19'h00C00, 3);
    chk({8'h00, srs}, 16'h0000);
    chk({15'h0, srqLine_n}, 16'h0001);
    rd(SEL_QU_EVENT);
    chk(d, 16'h0040);
    wr(3'h4, 16'h0018);
    drv(19'h30000, 3);
    chk({8'h00, srs}, 16'h0058);
    wr(3'h1, 16'h0200);
    wr(3'h4, 16'h0080);
    drv(19'h00010, 3);
    chk({8'h00, srs}, 16'h00C0);
    rd(SEL_SUMMARY);
    chk(d, 16'h00C0);
    rd(SEL_OP_COND);
    chk(d, 16'h0000);
    rd(SEL_OP_EVENT);
    chk(d, 16'h0200);
    drv(19'h00003, 3);
    drv(19'h00002, 3);
    rd(SEL_OP_COND);
    chk(d, 16'h0020);
    drv(19'h00006, 5);
    rd(SEL_OP_COND);
    chk(d, 16'h0000);
    @(posedge core_clk);
    clkEn <= 1'b0;
    drv(19'h00020, 3);
    rd(SEL_OP_COND);
    chk(d, 16'h0000);
    @(posedge core_clk);
    clkEn <= 1'b1;
    rd(SEL_OP_COND);
    chk(d, 16'h0100);
    complete_run();
  end
endmodule
